/* File: t1xf_line_coder.sv */
// ami / b8zs bipolar line coder with eight bit look-ahead
`timescale 1ns/1ps
`default_nettype none
module t1xf_line_coder (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // serial data and mode
   input wire logic bit_in,
   input wire logic b8zs_en,
   // bipolar outputs
   output logic line_pos,
   output logic line_neg
);
   t1xf_pkg::t1xf_lc_state_t q, d;

   // the window always delays by eight bits so that ami and b8zs share
   // one latency and switching mode never reorders bits
   always_comb begin
      d = q;
      d.pulse = {q.pulse[6:0], bit_in};
      d.viol = {q.viol[6:0], 1'b0};
      if (b8zs_en && d.pulse == 8'h00) begin
         d.pulse = t1xf_pkg::B8ZS_PULSE;
         d.viol = t1xf_pkg::B8ZS_VIOL;
      end
      d.pos = 1'b0;
      d.neg = 1'b0;
      if (q.pulse[7]) begin
         // a violation repeats the last polarity, a mark alternates
         if (!q.viol[7]) begin
            d.pol = ~q.pol;
         end
         d.pos = d.pol;
         d.neg = ~d.pol;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign line_pos = q.pos;
   assign line_neg = q.neg;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_ami_no_viol: assert property (!b8zs_en [*8] |=> q.viol == 8'h00)
      else $error("violation marked while ami coding selected");
   a_pulse_polar: assert property (!(line_pos && line_neg))
      else $error("both bipolar outputs active");
endmodule
`default_nettype wire

/* File: t1xf_line_sink.sv */
// line interface model: counts marks and bipolar violations on the line
`timescale 1ns/1ps
`default_nettype none
module t1xf_line_sink (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // bipolar line from the framer
   input wire logic line_pos,
   input wire logic line_neg,
   // running counts
   output logic [31:0] ones_cnt,
   output logic [31:0] viol_cnt,
   output logic [31:0] both_cnt
);
   logic last_neg_q;
   logic seen_q;

   // a mark of the same polarity as the one before is a violation;
   // the first mark after reset has nothing to compare against
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ones_cnt <= 32'h0;
         viol_cnt <= 32'h0;
         both_cnt <= 32'h0;
         last_neg_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         if (line_pos && line_neg) begin
            both_cnt <= both_cnt + 32'h1;
         end
         if (line_pos ^ line_neg) begin
            ones_cnt <= ones_cnt + 32'h1;
            last_neg_q <= line_neg;
            seen_q <= 1'b1;
            if (seen_q && (line_neg == last_neg_q)) begin
               viol_cnt <= viol_cnt + 32'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: t1xf_pkg.sv */
// shared constants and types of the t1 transmit framer
package t1xf_pkg;
   // register map
   localparam logic [7:0] ADDR_CFG = 8'h54;
   localparam logic [7:0] ADDR_ALM = 8'h55;
   localparam logic [7:0] ADDR_IBC = 8'h56;
   localparam logic [7:0] ADDR_PAT = 8'h57;
   localparam logic [7:0] ADDR_STAT = 8'hf0;
   // reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [1:0] ALM_RST = 2'h0;
   localparam logic [3:0] IBC_RST = 4'h0;
   localparam logic [7:0] PAT_RST = 8'h00;
   // field positions of transmit_framing_config
   localparam int CFG_TRK = 7;
   localparam int CFG_JPN = 6;
   localparam int CFG_B8ZS = 5;
   localparam int CFG_FMT_HI = 4;
   localparam int CFG_FMT_LO = 2;
   localparam int CFG_ZCS_HI = 1;
   // transmit_alarm_control
   localparam int ALM_YEL = 1;
   localparam int ALM_AIS = 0;
   // inband_code_control, stored as {en, uf, cl[1:0]}
   localparam int IBC_EN = 7;
   localparam int IBC_UF = 6;
   localparam int IBC_CL_HI = 1;
   // framing formats
   localparam logic [2:0] FMT_SF = 3'h0;
   localparam logic [2:0] FMT_DM = 3'h1;
   localparam logic [2:0] FMT_SLC = 3'h2;
   localparam logic [2:0] FMT_DMR = 3'h3;
   localparam logic [2:0] FMT_ESF = 3'h4;
   // frame geometry
   localparam logic [7:0] POS_LAST = 8'hc0;
   localparam logic [7:0] POS_LAST_LOAD = 8'hb8;
   localparam logic [4:0] CHAN_LAST = 5'h17;
   localparam logic [4:0] SF_FRAME_LAST = 5'h0b;
   localparam logic [4:0] ESF_FRAME_LAST = 5'h17;
   localparam logic [11:0] SF_FBITS = 12'h8dc;
   localparam logic [5:0] ESF_FPS = 6'h0b;
   localparam logic [15:0] YEL_BOC = 16'hff00;
   // data-mode sync byte with y and r at one
   localparam logic [7:0] DM_SYNC = 8'hbe;
   localparam int DM_Y = 2;
   localparam int DM_R = 1;
   // zero code suppression
   localparam logic [1:0] ZCS_NONE = 2'h0;
   localparam logic [1:0] ZCS_B8 = 2'h1;
   localparam logic [1:0] ZCS_DDS = 2'h2;
   localparam logic [7:0] ZCS_DDS_BYTE = 8'h98;
   localparam logic [5:0] CRC_POLY = 6'h03;
   // b8zs substitution 000vb0vb, oldest bit in position 7
   localparam logic [7:0] B8ZS_PULSE = 8'h1b;
   localparam logic [7:0] B8ZS_VIOL = 8'h12;

   typedef struct packed {
      logic [7:0] data;
      logic idle;
      logic channel_signalling_zero;
      logic [1:0] zcs;
   } t1xf_chan_t;

   typedef struct packed {
      logic [7:0] cfg;
      logic [1:0] alm;
      logic [3:0] ibc;
      logic [2:0] fmt;
      logic [7:0] pos;
      logic [4:0] frame;
      logic [4:0] chan;
      logic [7:0] sh;
      logic [5:0] crc;
      logic [5:0] crc_out;
      logic [3:0] boc_idx;
      logic [2:0] code_idx;
      logic line_bit;
      logic [7:0] rdata;
   } t1xf_state_t;

   typedef struct packed {
      logic [7:0] pulse;
      logic [7:0] viol;
      logic pol;
      logic pos;
      logic neg;
   } t1xf_lc_state_t;
endpackage

/* File: t1xf_top.sv */
// t1 transmit basic framer with in-band loop code generator
`timescale 1ns/1ps
`default_nettype none
module t1xf_top #(
   parameter logic [7:0] IDLE_CODE = 8'h7f
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // global e1 mode select
   input wire logic global_line_mode_select,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // channel source
   input wire t1xf_pkg::t1xf_chan_t chan_in,
   output logic [4:0] chan_sel,
   input wire logic fdl_bit,
   // bipolar line
   output logic line_pos,
   output logic line_neg
);
   t1xf_pkg::t1xf_state_t q, d;
   logic [7:0] pat_q;
   logic hold;
   logic ld;
   logic sig_frame;
   logic trk;
   logic japanese_variant_enable;
   logic yel;
   logic en;
   logic uf;
   logic dm_sync;
   logic [1:0] zeff;
   logic [7:0] zbyte;
   logic [2:0] fidx;
   logic [2:0] code_last;
   logic code_bit;

   assign hold = global_line_mode_select;
   assign trk = q.cfg[t1xf_pkg::CFG_TRK];
   assign japanese_variant_enable = q.cfg[t1xf_pkg::CFG_JPN];
   assign yel = q.alm[t1xf_pkg::ALM_YEL];
   assign en = q.ibc[3];
   assign uf = q.ibc[2];
   // a byte is loaded in the cycle before its channel starts
   assign ld = (q.pos[2:0] == 3'h0) && (q.pos <= t1xf_pkg::POS_LAST_LOAD);
   assign sig_frame = (q.frame == 5'h05) || (q.frame == 5'h0b) ||
                      (q.frame == 5'h11) || (q.frame == 5'h17);
   assign dm_sync = (q.chan == t1xf_pkg::CHAN_LAST) &&
                    ((q.fmt == t1xf_pkg::FMT_DM) ||
                     (q.fmt == t1xf_pkg::FMT_DMR));
   // global and per-channel codes combine bit by bit
   assign zeff = q.cfg[t1xf_pkg::CFG_ZCS_HI:0] | chan_in.zcs;
   assign fidx = 3'(q.frame >> 2);
   assign code_last = 3'(q.ibc[1:0]) + 3'h4;
   assign code_bit = pat_q[3'h7 - q.code_idx];

   t1xf_zcs u_zcs (
      .byte_in(chan_in.data),
      .code(zeff),
      .sig_frame(sig_frame),
      .byte_out(zbyte)
   );

   // next state of the whole framer
   always_comb begin
      logic fb;
      logic bt;
      logic crc_in;
      logic [7:0] b;
      logic [5:0] crc_n;
      fb = 1'b1;
      bt = 1'b0;
      crc_in = 1'b0;
      b = 8'h00;
      crc_n = 6'h00;
      d = q;
      d.rdata = 8'h00;

      // register writes; a reserved format leaves the old one in force
      if (reg_wr) begin
         unique case (reg_addr)
            t1xf_pkg::ADDR_CFG: begin
               d.cfg = reg_wdata;
               if (reg_wdata[t1xf_pkg::CFG_FMT_HI:t1xf_pkg::CFG_FMT_LO]
                   <= t1xf_pkg::FMT_ESF) begin
                  d.fmt = reg_wdata[t1xf_pkg::CFG_FMT_HI:
                                    t1xf_pkg::CFG_FMT_LO];
               end
            end
            t1xf_pkg::ADDR_ALM: d.alm = reg_wdata[1:0];
            t1xf_pkg::ADDR_IBC: d.ibc = {reg_wdata[t1xf_pkg::IBC_EN],
               reg_wdata[t1xf_pkg::IBC_UF],
               reg_wdata[t1xf_pkg::IBC_CL_HI:0]};
            default: d.cfg = q.cfg;
         endcase
      end

      // read data stands in the cycle after the strobe only
      if (reg_rd) begin
         unique case (reg_addr)
            t1xf_pkg::ADDR_CFG: d.rdata = q.cfg;
            t1xf_pkg::ADDR_ALM: d.rdata = {6'h00, q.alm};
            t1xf_pkg::ADDR_IBC: d.rdata = {q.ibc[3:2], 4'h0, q.ibc[1:0]};
            t1xf_pkg::ADDR_PAT: d.rdata = pat_q;
            t1xf_pkg::ADDR_STAT: d.rdata = {q.fmt, q.frame};
            default: d.rdata = 8'h00;
         endcase
      end

      // bit and frame counters
      if (q.pos == t1xf_pkg::POS_LAST) begin
         d.pos = 8'h00;
         if ((q.frame == t1xf_pkg::ESF_FRAME_LAST) ||
             (q.frame == t1xf_pkg::SF_FRAME_LAST &&
              q.fmt != t1xf_pkg::FMT_ESF)) begin
            d.frame = 5'h00;
         end else begin
            d.frame = q.frame + 5'h01;
         end
      end else begin
         d.pos = q.pos + 8'h01;
      end

      // channel byte: suppression, trunk, signalling, yellow, dm sync
      d.sh = {q.sh[6:0], 1'b0};
      if (ld) begin
         b = zbyte;
         if (chan_in.idle || trk) begin
            b = IDLE_CODE;
         end
         if ((chan_in.channel_signalling_zero || trk) && sig_frame) begin
            b[0] = 1'b0;
         end
         if (yel && (q.fmt == t1xf_pkg::FMT_SLC ||
             (q.fmt == t1xf_pkg::FMT_SF && !japanese_variant_enable))) begin
            b[6] = 1'b0;
         end
         if (dm_sync) begin
            b = t1xf_pkg::DM_SYNC;
            b[t1xf_pkg::DM_Y] = ~yel;
            if (q.fmt == t1xf_pkg::FMT_DMR) begin
               b[t1xf_pkg::DM_R] = fdl_bit;
            end
         end
         d.sh = b;
         d.chan = (q.chan == t1xf_pkg::CHAN_LAST) ? 5'h00 :
                  q.chan + 5'h01;
      end

      // framing bit of the current frame
      if (q.fmt == t1xf_pkg::FMT_ESF) begin
         if (!q.frame[0]) begin
            // link bit; yellow sends the alarm code word
            if (yel) begin
               fb = t1xf_pkg::YEL_BOC[4'hf - q.boc_idx];
            end else begin
               fb = fdl_bit;
            end
            if (q.pos == 8'h00) begin
               d.boc_idx = q.boc_idx + 4'h1;
            end
         end else if (q.frame[1:0] == 2'h1) begin
            fb = q.crc_out[3'h5 - fidx];
         end else begin
            fb = t1xf_pkg::ESF_FPS[3'h5 - fidx];
         end
      end else begin
         fb = t1xf_pkg::SF_FBITS[4'hb - 4'(q.frame)];
         if (japanese_variant_enable && yel && q.fmt == t1xf_pkg::FMT_SF &&
             q.frame == t1xf_pkg::SF_FRAME_LAST) begin
            fb = 1'b1;
         end
      end
      if (!yel) begin
         d.boc_idx = 4'h0;
      end

      // line bit: framing slot or payload, then code, then alarm
      bt = (q.pos == 8'h00) ? fb : q.sh[7];
      if (uf && q.pos == 8'h00) begin
         bt = 1'b1;
      end
      if (en && (q.pos != 8'h00 || uf)) begin
         bt = code_bit;
         d.code_idx = (q.code_idx == code_last) ? 3'h0 :
                      q.code_idx + 3'h1;
      end
      // a control write or e1 mode restarts the code at its msb, so a
      // shorter length never strands the index past its end
      if (!en || hold || (reg_wr && reg_addr == t1xf_pkg::ADDR_IBC)) begin
         d.code_idx = 3'h0;
      end

      // crc-6 over the superframe; the japanese variant covers f bits
      crc_in = bt;
      if (q.pos == 8'h00) begin
         crc_in = japanese_variant_enable ? fb : 1'b1;
      end
      crc_n = {q.crc[4:0], 1'b0} ^
              ((q.crc[5] ^ crc_in) ? t1xf_pkg::CRC_POLY : 6'h00);
      d.crc = crc_n;
      if (q.pos == t1xf_pkg::POS_LAST && d.frame == 5'h00) begin
         d.crc_out = crc_n;
         d.crc = 6'h00;
      end

      if (q.alm[t1xf_pkg::ALM_AIS]) begin
         bt = 1'b1;
      end
      d.line_bit = bt;

      // e1 mode keeps the register bank cleared
      if (hold) begin
         d.cfg = t1xf_pkg::CFG_RST;
         d.alm = t1xf_pkg::ALM_RST;
         d.ibc = t1xf_pkg::IBC_RST;
         d.fmt = t1xf_pkg::FMT_SF;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // no reset: the pattern must outlive a chip reset
   always_ff @(posedge core_clk) begin
      if (hold) begin
         pat_q <= t1xf_pkg::PAT_RST;
      end else if (reg_wr && reg_addr == t1xf_pkg::ADDR_PAT) begin
         pat_q <= reg_wdata;
      end
   end

   t1xf_line_coder u_coder (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .bit_in(q.line_bit),
      .b8zs_en(q.cfg[t1xf_pkg::CFG_B8ZS]),
      .line_pos(line_pos),
      .line_neg(line_neg)
   );

   assign reg_rdata = q.rdata;
   assign chan_sel = q.chan;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_code_start;
      en && !uf && q.pos != 8'h00 && q.code_idx == 3'h0;
   endsequence

   a_mode_hold_cfg: assert property (hold |=> q.cfg == 8'h00 &&
      q.alm == 2'h0 && q.ibc == 4'h0)
      else $error("register bank not held in e1 mode");
   a_trunk_idle: assert property ((trk && ld && !sig_frame && !yel &&
      !dm_sync) |=> q.sh == IDLE_CODE)
      else $error("trunk conditioning did not load idle code");
   a_jpn_sf_yel: assert property ((japanese_variant_enable && yel && q.fmt == 3'h0 &&
      q.pos == 8'h00 && q.frame == 5'h0b && !en && !uf &&
      !q.alm[0]) |=> q.line_bit)
      else $error("frame 12 f bit not forced for yellow");
   a_yel_bit2: assert property ((yel && !japanese_variant_enable && q.fmt == 3'h0 && ld &&
      !dm_sync) |=> !q.sh[6])
      else $error("yellow did not clear bit 2");
   a_fmt_legal: assert property (q.fmt <= 3'h4)
      else $error("illegal framing format in force");
   a_reserved_keep: assert property ((reg_wr && reg_addr == 8'h54 &&
      reg_wdata[4:2] > 3'h4 && !hold) |=> $stable(q.fmt))
      else $error("reserved format changed the framing");
   a_zcs_nonzero: assert property ((ld && chan_in.data == 8'h00 &&
      zeff != 2'h0 && !chan_in.idle && !trk) |=> q.sh != 8'h00)
      else $error("all-zero byte left unsuppressed");
   a_ais_ones: assert property (q.alm[0] |=> q.line_bit)
      else $error("all-ones alarm sent a zero");
   a_code_off: assert property (!en |=> q.code_idx == 3'h0)
      else $error("code generator ran while disabled");
   a_code_wrap: assert property (q.code_idx <= code_last)
      else $error("code index passed the code length");
   a_code_msb: assert property (s_code_start ##0 !q.alm[0] |=>
      q.line_bit == $past(pat_q[7]))
      else $error("code did not start with its msb");
   a_uf_fslot: assert property ((uf && !en && q.pos == 8'h00) ##1
      !$past(q.alm[0]) |-> q.line_bit)
      else $error("framing inserted while unframed");
   // besides a write to its register, e1 mode is the one thing that may alter the pattern
   a_pat_mode_clr: assert property (hold |=> pat_q == 8'h00)
      else $error("pattern not cleared in e1 mode");
   a_trunk_sig: assert property (
      (trk && sig_frame && ld && !dm_sync) |=> !q.sh[0])
      else $error("trunk conditioning kept the signalling bit");
   a_dm_yel_y: assert property ((yel && dm_sync && ld) |=>
      !q.sh[t1xf_pkg::DM_Y])
      else $error("data-mode yellow left the y bit set");
   a_dmr_rbit: assert property ((dm_sync && ld &&
      q.fmt == t1xf_pkg::FMT_DMR) |=>
      q.sh[t1xf_pkg::DM_R] == $past(fdl_bit))
      else $error("link data did not replace the r bit");
   // a write to the code control restarts the code at its msb
   a_code_restart: assert property ((reg_wr &&
      reg_addr == t1xf_pkg::ADDR_IBC) |=> q.code_idx == 3'h0)
      else $error("code did not restart after a control write");
   // first two superframe f bits, away from unframed code and alarm
   a_sf_fbit_one: assert property ((q.fmt == t1xf_pkg::FMT_SF &&
      q.pos == 8'h00 && q.frame == 5'h00 && !uf && !q.alm[0]) |=>
      q.line_bit)
      else $error("first superframe f bit not one");
   a_sf_fbit_zero: assert property ((q.fmt == t1xf_pkg::FMT_SF &&
      q.pos == 8'h00 && q.frame == 5'h01 && !uf && !q.alm[0]) |=>
      !q.line_bit)
      else $error("second superframe f bit not zero");
endmodule
`default_nettype wire

/* File: t1xf_zcs.sv */
// zero code suppression of one channel byte
`timescale 1ns/1ps
`default_nettype none
module t1xf_zcs (
   // byte and selection
   input wire logic [7:0] byte_in,
   input wire logic [1:0] code,
   input wire logic sig_frame,
   // result
   output logic [7:0] byte_out
);
   // only an all-zero byte is touched
   always_comb begin
      byte_out = byte_in;
      if (byte_in == 8'h00) begin
         unique case (code)
            t1xf_pkg::ZCS_NONE: byte_out = byte_in;
            t1xf_pkg::ZCS_B8: begin
               if (sig_frame) begin
                  byte_out = 8'h02;
               end else begin
                  byte_out = 8'h01;
               end
            end
            t1xf_pkg::ZCS_DDS: byte_out = t1xf_pkg::ZCS_DDS_BYTE;
            default: byte_out = 8'h02;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the t1 transmit framer
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; \
   if ((got) !== (exp)) begin num_errors++; \
   $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb;
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] alm;
      logic [7:0] ibc;
      logic [7:0] pat;
      logic [1:0] zcs;
      logic [7:0] data;
      int len;
      int ones;
      logic b8;
   } t1xf_row_t;

   // one superframe, its payload bytes, its f ones, and an lcm of 5..8
   localparam int W = 12 * 193;
   localparam int P = 12 * 24;
   localparam int F = 6;
   localparam int U = 840;
   localparam int LIMIT = 85000;

   // settings and the marks expected on the line over the window
   localparam t1xf_row_t rows [21] = '{
      '{8'h00, 8'h00, 8'h00, 8'hb3, 2'h0, 8'h00, W, F, 1'b0},
      '{8'h02, 8'h00, 8'h00, 8'hb3, 2'h0, 8'h00, W, P*3+F, 1'b0},
      '{8'h01, 8'h00, 8'h00, 8'hb3, 2'h2, 8'h00, W, P+F, 1'b0},
      '{8'h00, 8'h00, 8'h00, 8'hb3, 2'h1, 8'h00, W, P+F, 1'b0},
      '{8'h02, 8'h00, 8'h00, 8'hb3, 2'h0, 8'h81, W, P*2+F, 1'b0},
      '{8'h00, 8'h00, 8'h00, 8'hb3, 2'h0, 8'hff, W, P*8+F, 1'b0},
      '{8'h00, 8'h02, 8'h00, 8'hb3, 2'h0, 8'hff, W, P*7+F, 1'b0},
      '{8'h40, 8'h02, 8'h00, 8'hb3, 2'h0, 8'hff, W, P*8+F+1, 1'b0},
      '{8'h80, 8'h00, 8'h00, 8'hb3, 2'h0, 8'hff, W, 1680+288+F, 1'b0},
      '{8'h08, 8'h02, 8'h00, 8'hb3, 2'h0, 8'hff, W, P*7+F, 1'b0},
      '{8'h04, 8'h00, 8'h00, 8'hb3, 2'h0, 8'h00, W, 12*6+F, 1'b0},
      '{8'h14, 8'h00, 8'h00, 8'hb3, 2'h0, 8'h00, W, 12*6+F, 1'b0},
      '{8'h0c, 8'h00, 8'h00, 8'hb3, 2'h0, 8'h00, W, 12*5+F, 1'b0},
      '{8'h04, 8'h02, 8'h00, 8'hb3, 2'h0, 8'h00, W, 12*5+F, 1'b0},
      '{8'h00, 8'h01, 8'h00, 8'hb3, 2'h0, 8'h00, W, W, 1'b0},
      '{8'h00, 8'h00, 8'h40, 8'hb3, 2'h0, 8'h00, W, 12, 1'b0},
      '{8'h00, 8'h00, 8'h83, 8'hb3, 2'h0, 8'h00, W, P*5+F, 1'b0},
      '{8'h00, 8'h00, 8'hc0, 8'hb3, 2'h0, 8'h00, U, U/5*3, 1'b0},
      '{8'h00, 8'h00, 8'hc2, 8'hb3, 2'h0, 8'h00, U, U/7*4, 1'b0},
      '{8'h00, 8'h00, 8'hc1, 8'h6c, 2'h0, 8'h00, U, U/6*4, 1'b0},
      '{8'h20, 8'h00, 8'h00, 8'hb3, 2'h0, 8'h00, W, 0, 1'b1}
   };

   logic core_clk;
   logic rst_n;
   logic global_line_mode_select;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   t1xf_pkg::t1xf_chan_t chan_in;
   logic fdl_bit;
   logic line_pos;
   logic line_neg;
   logic [31:0] ones_cnt;
   logic [31:0] viol_cnt;
   logic [31:0] both_cnt;
   logic [7:0] rd_val;
   logic [31:0] base_cnt;
   logic [31:0] link_zero;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;

   t1xf_top #(.IDLE_CODE(8'h7f)) t1xf_top_inst (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .global_line_mode_select(global_line_mode_select),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .chan_in(chan_in),
      .chan_sel(),
      .fdl_bit(fdl_bit),
      .line_pos(line_pos),
      .line_neg(line_neg)
   );

   t1xf_line_sink t1xf_line_sink_inst (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .line_pos(line_pos),
      .line_neg(line_neg),
      .ones_cnt(ones_cnt),
      .viol_cnt(viol_cnt),
      .both_cnt(both_cnt)
   );

   // 200 mhz core clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic tally_and_finish;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // a hang ends the run through the same report
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         num_errors++;
         tally_and_finish();
      end
   end

   // one-cycle write strobe, released at the next edge
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe edge
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // program one setting, let the pipeline settle, count marks
   task automatic run_row(input t1xf_row_t r);
      logic [31:0] o0;
      logic [31:0] v0;
      chan_in <= {r.data, 1'b0, 1'b0, r.zcs};
      reg_write(t1xf_pkg::ADDR_CFG, r.cfg);
      reg_write(t1xf_pkg::ADDR_ALM, r.alm);
      reg_write(t1xf_pkg::ADDR_PAT, r.pat);
      reg_write(t1xf_pkg::ADDR_IBC, r.ibc);
      repeat (300) @(posedge core_clk);
      o0 = ones_cnt;
      v0 = viol_cnt;
      repeat (r.len) @(posedge core_clk);
      `CHK("violations", r.b8, (viol_cnt != v0))
      if (!r.b8) `CHK("marks", 32'(r.ones), ones_cnt - o0)
   endtask

   initial begin
      rst_n = 1'b0;
      global_line_mode_select = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      chan_in = '0;
      fdl_bit = 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) run_row(rows[i]);
      // esf: a superframe holds 12 link slots, so fdl_bit high adds 12
      // marks; the crc counts f slots as one and does not move, but the
      // superframe cut by the format change needs two to wash out
      reg_write(t1xf_pkg::ADDR_CFG, 8'h10);
      repeat (4 * W + 300) @(posedge core_clk);
      base_cnt = ones_cnt;
      repeat (2 * W) @(posedge core_clk);
      link_zero = ones_cnt - base_cnt;
      fdl_bit <= 1'b1;
      repeat (300) @(posedge core_clk);
      base_cnt = ones_cnt;
      repeat (2 * W) @(posedge core_clk);
      `CHK("esf link marks", link_zero + 32'hc, ones_cnt - base_cnt)
      fdl_bit <= 1'b0;
      `CHK("line both high", 32'h0, both_cnt)
      // chip reset mid-run: config cleared, pattern kept
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      reg_read(t1xf_pkg::ADDR_PAT, rd_val);
      `CHK("pattern after reset", 8'hb3, rd_val)
      @(posedge core_clk);
      #1 `CHK("rdata after read", 8'h00, reg_rdata)
      for (int a = 8'h54; a < 8'h57; a++) begin
         reg_read(8'(a), rd_val);
         `CHK("reset value", 8'h00, rd_val)
      end
      // unmapped place reads zero, writes there change nothing
      reg_write(8'h60, 8'hff);
      reg_read(8'h60, rd_val);
      `CHK("unmapped", 8'h00, rd_val)
      // readback masks of the four registers, back to back
      reg_write(t1xf_pkg::ADDR_CFG, 8'ha5);
      reg_write(t1xf_pkg::ADDR_ALM, 8'hff);
      reg_write(t1xf_pkg::ADDR_IBC, 8'hff);
      reg_write(t1xf_pkg::ADDR_PAT, 8'h5a);
      reg_read(t1xf_pkg::ADDR_CFG, rd_val);
      `CHK("cfg", 8'ha5, rd_val)
      reg_read(t1xf_pkg::ADDR_ALM, rd_val);
      `CHK("alm", 8'h03, rd_val)
      reg_read(t1xf_pkg::ADDR_IBC, rd_val);
      `CHK("ibc", 8'hc3, rd_val)
      reg_read(t1xf_pkg::ADDR_PAT, rd_val);
      `CHK("pattern", 8'h5a, rd_val)
      reg_read(t1xf_pkg::ADDR_STAT, rd_val);
      `CHK("format in force", 3'h1, rd_val[7:5])
      // e1 mode clears the bank, a write meanwhile is lost
      @(posedge core_clk);
      global_line_mode_select <= 1'b1;
      reg_write(t1xf_pkg::ADDR_CFG, 8'hff);
      @(posedge core_clk);
      global_line_mode_select <= 1'b0;
      for (int a = 8'h54; a < 8'h58; a++) begin
         reg_read(8'(a), rd_val);
         `CHK("held in e1 mode", 8'h00, rd_val)
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
